// >>> inc/dcpr_consts.vh
`ifndef DCPR_CONSTS_VH
`define DCPR_CONSTS_VH
// port b pin positions
`define DCPR_PIN_B_RX     3'h4
`define DCPR_PIN_A_RX     3'h5
`define DCPR_PIN_A_TX     3'h6
`define DCPR_PIN_B_TX     3'h7
// controller select address bit
`define DCPR_SEL_ADDR_BIT 8
// reset values of the controller selects
`define DCPR_SEL_A_RST    1'b1
`define DCPR_SEL_B_RST    1'b0
// segment address lines with and without a controller in use
`define DCPR_SEG_LIMITED  4'h4
`define DCPR_SEG_FULL     4'h8
// shared peripheral interrupt vectors
`define DCPR_IRQ_VECTORS  4
// identifier widths
`define DCPR_STD_ID_W     11
`define DCPR_EXT_ID_W     29
`endif

// >>> rtl/dcpr_pin_sync.v
`timescale 1ns/1ps
module dcpr_pin_sync #(
    parameter WIDTH = 8
) (
    input  wire             clk_i,
    input  wire             rst_n_i,
    input  wire [WIDTH-1:0] pin_i,
    output reg  [WIDTH-1:0] level_o
);
    reg [WIDTH-1:0] s1_reg;
    reg [WIDTH-1:0] s2_reg;
    reg [WIDTH-1:0] s3_reg;
    // first stage read only by second; change taken once stages 2 and 3 agree
    always @(posedge clk_i or negedge rst_n_i)
    begin
        if (!rst_n_i)
        begin
            s1_reg  <= {WIDTH{1'b1}};
            s2_reg  <= {WIDTH{1'b1}};
            s3_reg  <= {WIDTH{1'b1}};
            level_o <= {WIDTH{1'b1}};
        end
        else
        begin
            s1_reg  <= pin_i;
            s2_reg  <= s1_reg;
            s3_reg  <= s2_reg;
            level_o <= (s2_reg & s3_reg) | (~(s2_reg ^ s3_reg) & s3_reg) |
                       (level_o & (s2_reg ^ s3_reg));
        end
    end
endmodule

// >>> rtl/dcpr_port_route.v
`timescale 1ns/1ps
`include "dcpr_consts.vh"
// What this block does
// - both controllers handle 11-bit standard and 29-bit extended frames over these lines.
// - controllers share one register layout and are told apart by address bit 8, each with its own select.
// - controller a transmits on port b bit 6 and receives from bit 5.
// - in default mapping controller b transmits on bit 7 and receives from bit 4.
// - both controllers' interrupts merge onto the four shared peripheral interrupt lines.
// - after reset controller a is selected and controller b is not.
// - with any controller in use port b drives at most four segment address lines.
// - on one shared bus both controllers together give up to 64 message objects over joined lines.
// - both transmit outputs can be open drain under the port b open-drain register.
// - with pin sharing set both controllers receive from bit 5 and b's transmit joins a's on bit 6 while a is live, freeing bits 4 and 7.
// - the misc register is writable only while its access enable and the global enable are set.
// - with the two-wire enable set bits 4 and 7 become open-drain clock and data lines.
// - with the two-wire enable clear bit 4 returns to port control and bit 7 to port control or, while live and unshared, controller b transmit.
module dcpr_port_route #(
    parameter ADDR_W = 24
) (
    input  wire              clk_i,
    input  wire              rst_n_i,
    // cpu side
    input  wire [ADDR_W-1:0] addr_i,
    input  wire              periph_cs_i,
    input  wire              sel_wr_i,
    input  wire              sel_a_i,
    input  wire              sel_b_i,
    input  wire              misc_en_i,
    input  wire              global_en_i,
    input  wire              misc_wr_i,
    input  wire              pin_share_i,
    input  wire              two_wire_en_i,
    input  wire [7:0]        port_data_i,
    input  wire [7:0]        port_dir_i,
    input  wire [7:0]        port_od_i,
    input  wire [7:0]        seg_addr_i,
    // controller side
    input  wire              ctrl_a_tx_i,
    input  wire              ctrl_b_tx_i,
    input  wire [`DCPR_IRQ_VECTORS-1:0] ctrl_a_irq_i,
    input  wire [`DCPR_IRQ_VECTORS-1:0] ctrl_b_irq_i,
    input  wire [`DCPR_IRQ_VECTORS-1:0] other_irq_i,
    input  wire              tw_scl_i,
    input  wire              tw_sda_i,
    // pins
    input  wire [7:0]        pin_i,
    output reg  [7:0]        pin_o,
    output reg  [7:0]        pin_oe_n_o,
    // status and routed signals
    output reg               ctrl_a_rx_o,
    output reg               ctrl_b_rx_o,
    output reg               ctrl_a_cs_o,
    output reg               ctrl_b_cs_o,
    output reg               ctrl_a_on_o,
    output reg               ctrl_b_on_o,
    output reg               pin_share_o,
    output reg  [7:0]        seg_addr_o,
    output reg  [3:0]        seg_lines_o,
    output reg  [`DCPR_IRQ_VECTORS-1:0] irq_o,
    output reg               tw_scl_o,
    output reg               tw_sda_o
);
    // reset release
    reg        rst_s1_reg;
    reg        rst_s2_reg;
    wire       rst_n;
    // select and misc state
    reg        sel_a_reg;
    reg        sel_b_reg;
    reg        share_reg;
    wire       live_a;
    wire       live_b;
    // pad and interrupt drive
    wire [7:0] pin_lvl;
    reg  [7:0] port_oe_n;
    reg  [7:0] pin_next;
    reg  [7:0] oe_n_next;
    reg        tx_a_eff;
    reg        tx_b_eff;
    reg        in_use;
    reg  [`DCPR_IRQ_VECTORS-1:0] irq_next;
    integer    i;
    integer    v;

    // reset release through two flops
    // release is synchronous so every flop leaves reset on one edge
    always @(posedge clk_i or negedge rst_n_i)
    begin
        if (!rst_n_i)
        begin
            rst_s1_reg <= 1'b0;
            rst_s2_reg <= 1'b0;
        end
        else
        begin
            rst_s1_reg <= 1'b1;
            rst_s2_reg <= rst_s1_reg;
        end
    end
    assign rst_n = rst_s2_reg;

    dcpr_pin_sync #(
        .WIDTH (8)
    ) u_sync (
        .clk_i   (clk_i),
        .rst_n_i (rst_n),
        .pin_i   (pin_i),
        .level_o (pin_lvl)
    );

    // open-drain drive: low pulls, high releases
    function [1:0] od_drive;
        input val;
        begin
            od_drive = val ? 2'b11 : 2'b00;
        end
    endfunction

    // controller transmit onto a pad, push-pull or open drain
    function [1:0] tx_drive;
        input tx;
        input od;
        begin
            if (od)
                tx_drive = od_drive(tx);
            else
                tx_drive = {tx, 1'b0};
        end
    endfunction

    // a controller counts only once the global enable is up
    function ctrl_live;
        input glob;
        input sel;
        begin
            ctrl_live = glob & sel;
        end
    endfunction

    assign live_a = ctrl_live(global_en_i, sel_a_reg);
    assign live_b = ctrl_live(global_en_i, sel_b_reg);

    // selects only change while global enable is clear
    always @(posedge clk_i or negedge rst_n)
    begin
        if (!rst_n)
        begin
            sel_a_reg <= `DCPR_SEL_A_RST;
            sel_b_reg <= `DCPR_SEL_B_RST;
        end
        else if (sel_wr_i && !global_en_i)
        begin
            sel_a_reg <= sel_a_i;
            sel_b_reg <= sel_b_i;
        end
    end

    // misc register; a refused write leaves no trace
    always @(posedge clk_i or negedge rst_n)
    begin
        if (!rst_n)
            share_reg <= 1'b0;
        // misc write gated by both enables
        else if (misc_wr_i && misc_en_i && global_en_i)
            share_reg <= pin_share_i;
    end

    // effective transmit levels and segment use
    always @*
    begin
        in_use   = live_a | live_b;
        tx_a_eff = share_reg ? (ctrl_a_tx_i & ctrl_b_tx_i) : ctrl_a_tx_i;
        tx_b_eff = ctrl_b_tx_i;
    end

    // port registers alone, before any alternate function
    always @*
    begin
        port_oe_n = 8'hFF;
        for (i = 0; i < 8; i = i + 1)
        begin
            if (port_dir_i[i])
            begin
                // port open drain releases on one
                if (port_od_i[i])
                    port_oe_n[i] = port_data_i[i];
                else
                    port_oe_n[i] = 1'b0;
            end
        end
    end

    always @*
    begin
        pin_next  = port_data_i;
        oe_n_next = port_oe_n;
        // controller a transmit on bit 6
        // open drain per port b register
        if (live_a && port_dir_i[`DCPR_PIN_A_TX])
            {pin_next[`DCPR_PIN_A_TX], oe_n_next[`DCPR_PIN_A_TX]} =
                tx_drive(tx_a_eff, port_od_i[`DCPR_PIN_A_TX]);
        // controller b transmit on bit 7 unless shared
        if (live_b && !share_reg && port_dir_i[`DCPR_PIN_B_TX])
            {pin_next[`DCPR_PIN_B_TX], oe_n_next[`DCPR_PIN_B_TX]} =
                tx_drive(tx_b_eff, port_od_i[`DCPR_PIN_B_TX]);
        // two-wire takes bits 4 and 7 as open drain
        // two-wire wins over controller b on bit 7
        if (two_wire_en_i)
        begin
            {pin_next[`DCPR_PIN_B_RX], oe_n_next[`DCPR_PIN_B_RX]} = od_drive(tw_scl_i);
            {pin_next[`DCPR_PIN_B_TX], oe_n_next[`DCPR_PIN_B_TX]} = od_drive(tw_sda_i);
        end
        // otherwise port registers or controller b transmit govern, set above
    end

    // per-vector merge of both controllers and others
    always @*
    begin
        irq_next = other_irq_i;
        for (v = 0; v < `DCPR_IRQ_VECTORS; v = v + 1)
        begin
            // a deselected controller must not reach the vectors
            if ((live_a && ctrl_a_irq_i[v]) || (live_b && ctrl_b_irq_i[v]))
                irq_next[v] = 1'b1;
        end
    end

    // pad drive, kept apart so the pins see one clean flop stage
    always @(posedge clk_i or negedge rst_n)
    begin
        if (!rst_n)
        begin
            // all pads released while in reset
            pin_o      <= 8'hFF;
            pin_oe_n_o <= 8'hFF;
            tw_scl_o   <= 1'b1;
            tw_sda_o   <= 1'b1;
        end
        else
        begin
            pin_o      <= pin_next;
            pin_oe_n_o <= oe_n_next;
            // two-wire reads back its own lines
            tw_scl_o   <= two_wire_en_i ? pin_lvl[`DCPR_PIN_B_RX] : 1'b1;
            tw_sda_o   <= two_wire_en_i ? pin_lvl[`DCPR_PIN_B_TX] : 1'b1;
        end
    end

    // receive routing; recessive in reset so no false start follows
    always @(posedge clk_i or negedge rst_n)
    begin
        if (!rst_n)
        begin
            ctrl_a_rx_o <= 1'b1;
            ctrl_b_rx_o <= 1'b1;
            pin_share_o <= 1'b0;
        end
        else
        begin
            // controller a receive from bit 5
            ctrl_a_rx_o <= pin_lvl[`DCPR_PIN_A_RX];
            // b receives bit 4 by default
            // shared pins feed bit 5 to both
            ctrl_b_rx_o <= share_reg ? pin_lvl[`DCPR_PIN_A_RX] : pin_lvl[`DCPR_PIN_B_RX];
            // sharing frees bits 4 and 7
            pin_share_o <= share_reg;
        end
    end

    // cpu side selects, segment lines and interrupts
    always @(posedge clk_i or negedge rst_n)
    begin
        if (!rst_n)
        begin
            ctrl_a_cs_o <= 1'b0;
            ctrl_b_cs_o <= 1'b0;
            ctrl_a_on_o <= 1'b0;
            ctrl_b_on_o <= 1'b0;
            seg_addr_o  <= 8'h00;
            seg_lines_o <= `DCPR_SEG_FULL;
            irq_o       <= {`DCPR_IRQ_VECTORS{1'b0}};
        end
        else
        begin
            // address bit 8 picks the controller
            // selects stay low until the global enable is up
            ctrl_a_cs_o <= periph_cs_i & live_a & ~addr_i[`DCPR_SEL_ADDR_BIT];
            ctrl_b_cs_o <= periph_cs_i & live_b & addr_i[`DCPR_SEL_ADDR_BIT];
            // controllers active carry both frame formats
            ctrl_a_on_o <= live_a;
            ctrl_b_on_o <= live_b;
            // upper segment lines dropped while in use
            seg_addr_o  <= in_use ? {4'h0, seg_addr_i[3:0]} : seg_addr_i;
            seg_lines_o <= in_use ? `DCPR_SEG_LIMITED : `DCPR_SEG_FULL;
            irq_o       <= irq_next;
        end
    end
endmodule

// >>> sim/dcpr_assertions.sv
`timescale 1ns/1ps
module dcpr_checker #(
    parameter ADDR_W = 24
) (
    input wire logic              clk_i, rst_n_i, periph_cs_i, global_en_i,
    input wire logic              misc_en_i, misc_wr_i, two_wire_en_i, tw_scl_i, tw_sda_i,
    input wire logic [ADDR_W-1:0] addr_i,
    input wire logic [7:0]        port_data_i, port_dir_i, port_od_i, pin_i, pin_oe_n_o,
    input wire logic [3:0]        ctrl_a_irq_i, ctrl_b_irq_i, other_irq_i, irq_o, seg_lines_o,
    input wire logic              ctrl_a_rx_o, ctrl_b_rx_o, ctrl_b_cs_o, ctrl_a_on_o,
    input wire logic              ctrl_b_on_o, pin_share_o
);
    // wait out the two-flop reset release before judging
    logic [2:0] live_reg;
    always @(posedge clk_i or negedge rst_n_i)
        if (!rst_n_i)
            live_reg <= 3'h0;
        else if (live_reg != 3'h7)
            live_reg <= live_reg + 3'h1;
    default clocking @(posedge clk_i); endclocking
    default disable iff (!rst_n_i || live_reg != 3'h7);
    irq_quiet_a: assert property ((ctrl_a_irq_i | ctrl_b_irq_i | other_irq_i) == 4'h0 |=> irq_o == 4'h0)
        else $error("irq without source");
    b_select_a: assert property (ctrl_b_cs_o |-> $past(addr_i[8] & periph_cs_i & global_en_i))
        else $error("b select without bit 8");
    seg_limit_a: assert property ((ctrl_a_on_o | ctrl_b_on_o) [*2] |-> seg_lines_o == 4'h4)
        else $error("segment lines not limited");
    tw_drive_a: assert property ($past(two_wire_en_i) |->
        pin_oe_n_o[4] == $past(tw_scl_i) && pin_oe_n_o[7] == $past(tw_sda_i))
        else $error("two-wire pins wrong");
    port_bit4_a: assert property (!$past(two_wire_en_i) |-> pin_oe_n_o[4] ==
        !$past(port_dir_i[4] & !(port_od_i[4] & port_data_i[4])))
        else $error("bit 4 not port driven");
    rx_a_pin_a: assert property ($stable(pin_i[5]) [*6] |-> ctrl_a_rx_o == pin_i[5])
        else $error("a receive not from bit 5");
    rx_b_share_a: assert property ((pin_share_o & $stable(pin_i[5])) [*6] |-> ctrl_b_rx_o == pin_i[5])
        else $error("b receive not from bit 5");
    misc_hold_a: assert property ($past(misc_wr_i & ~(misc_en_i & global_en_i)) |=> $stable(pin_share_o))
        else $error("misc write not refused");
endmodule
bind dcpr_port_route dcpr_checker #(.ADDR_W(ADDR_W)) u_dcpr_checker (.*);

// >>> sim/dcpr_xcvr_model.sv
`timescale 1ns/1ps
module dcpr_xcvr_model (
    input  wire logic [7:0] pin_o,
    input  wire logic [7:0] pin_oe_n_o,
    output logic      [7:0] pin_i
);
    logic [7:0] low;
    assign low = ~pin_oe_n_o & ~pin_o;
    // one transceiver, tx 6/7 and rx 4/5 joined
    assign pin_i = ~low & {2'h3, {2{~(low[6] | low[7])}}, 4'hF};
endmodule

// >>> sim/tb.sv
`timescale 1ns/1ps
module tb;
    logic        clk_i = 0, rst_n_i = 0, periph_cs_i = 0, sel_wr_i = 0, sel_a_i = 0, sel_b_i = 0;
    logic        misc_en_i = 0, global_en_i = 0, misc_wr_i = 0, pin_share_i = 0, two_wire_en_i = 0;
    logic        ctrl_a_tx_i = 1, ctrl_b_tx_i = 1, tw_scl_i = 1, tw_sda_i = 1;
    logic [23:0] addr_i = 0;
    logic [7:0]  port_data_i = 0, port_dir_i = 0, port_od_i = 0, seg_addr_i = 8'hA5;
    logic [3:0]  ctrl_a_irq_i = 0, ctrl_b_irq_i = 0, other_irq_i = 0, irq_o, seg_lines_o;
    logic [7:0]  pin_i, pin_o, pin_oe_n_o, seg_addr_o;
    logic        ctrl_a_rx_o, ctrl_b_rx_o, ctrl_a_cs_o, ctrl_b_cs_o, ctrl_a_on_o, ctrl_b_on_o;
    logic        pin_share_o, tw_scl_o, tw_sda_o;
    int          num_errors = 0, total_checks = 0;
    // a, b, other irq nibbles, then merged result
    logic [15:0] rows [4] = '{16'h1203, 16'h048C, 16'h842E, 16'h0000};
    always #2.5 clk_i = ~clk_i;
    dcpr_port_route u_dcpr_port_route (.*);
    dcpr_xcvr_model u_dcpr_xcvr_model (.pin_o(pin_o), .pin_oe_n_o(pin_oe_n_o), .pin_i(pin_i));
    task chk(string nm, logic [7:0] exp, logic [7:0] got);
        total_checks++;
        if (got !== exp)
        begin
            num_errors++;
            $display("BAD %s exp %h got %h", nm, exp, got);
        end
    endtask
    task cyc(int n);
        repeat (n) @(negedge clk_i);
    endtask
    task pulse_sel;
        sel_wr_i = 1;
        cyc(1);
        sel_wr_i = 0;
    endtask
    task pulse_misc;
        misc_wr_i = 1;
        cyc(1);
        misc_wr_i = 0;
        cyc(1);
    endtask
    task give_verdict;
        $display("checks %0d errors %0d", total_checks, num_errors);
        if (num_errors == 0 && total_checks > 0)
            $display("SIMULATION PASSED");
        else
            $display("SIMULATION FAILED");
        $finish;
    endtask
    initial
    begin
        #100000;
        num_errors++;
        give_verdict();
    end
    initial
    begin
        cyc(6);
        rst_n_i = 1;
        cyc(3);
        global_en_i = 1;
        periph_cs_i = 1;
        cyc(2);
        chk("a_cs", 1, ctrl_a_cs_o);
        chk("seg_lines", 4, seg_lines_o);
        addr_i[8] = 1;
        sel_b_i = 1;
        pulse_sel();
        cyc(1);
        chk("b_cs_off", 0, ctrl_b_cs_o);
        global_en_i = 0;
        sel_a_i = 1;
        pulse_sel();
        global_en_i = 1;
        cyc(2);
        chk("b_cs", 1, ctrl_b_cs_o);
        chk("a_cs_off", 0, ctrl_a_cs_o);
        chk("on_both", 3, {ctrl_a_on_o, ctrl_b_on_o});
        for (int i = 0; i < 4; i++)
        begin
            {ctrl_a_irq_i, ctrl_b_irq_i, other_irq_i} = rows[i][15:4];
            cyc(2);
            chk("irq", rows[i][3:0], irq_o);
        end
        port_dir_i = 8'hC0;
        port_od_i = 8'hC0;
        ctrl_b_tx_i = 0;
        cyc(8);
        chk("b_tx7", 0, {pin_oe_n_o[7], pin_o[7]});
        chk("rx_dom", 0, {ctrl_a_rx_o, ctrl_b_rx_o});
        ctrl_b_tx_i = 1;
        cyc(8);
        chk("od7", 1, pin_oe_n_o[7]);
        chk("rx_rec", 3, {ctrl_a_rx_o, ctrl_b_rx_o});
        two_wire_en_i = 1;
        tw_scl_i = 0;
        port_data_i = 8'hFF;
        cyc(8);
        chk("tw_oe", 2, {pin_oe_n_o[7], pin_oe_n_o[4]});
        chk("tw_in", 2, {tw_sda_o, tw_scl_o});
        two_wire_en_i = 0;
        cyc(2);
        chk("port4", 1, pin_oe_n_o[4]);
        chk("tw_idle", 3, {tw_sda_o, tw_scl_o});
        pin_share_i = 1;
        pulse_misc();
        chk("share_off", 0, pin_share_o);
        misc_en_i = 1;
        pulse_misc();
        chk("share_on", 1, pin_share_o);
        ctrl_b_tx_i = 0;
        cyc(8);
        chk("wand6", 0, pin_oe_n_o[6]);
        chk("rx_share", 0, {ctrl_a_rx_o, ctrl_b_rx_o});
        chk("free7", 1, pin_oe_n_o[7]);
        ctrl_b_tx_i = 1;
        rst_n_i = 0;
        cyc(1);
        chk("rst_lines", 8, seg_lines_o);
        chk("rst_share", 0, pin_share_o);
        rst_n_i = 1;
        cyc(4);
        chk("on_rst", 2, {ctrl_a_on_o, ctrl_b_on_o});
        chk("seg_addr", 8'h05, seg_addr_o);
        global_en_i = 0;
        cyc(2);
        chk("seg_full", 8'hA5, seg_addr_o);
        chk("on_off", 0, {ctrl_a_on_o, ctrl_b_on_o});
        give_verdict();
    end
endmodule
